// *** core/slsd_pkg.sv ***
// Purpose: shared constants and types of the shift/latch sink driver
// Assumes: all pins sampled on clk_in, synchronous to it
// Notes: one package for both design files
package slsd_pkg;

    localparam int unsigned SLSD_STAGES = 8;
    localparam int unsigned SLSD_FIFO_DEPTH = 16;
    localparam logic [7:0] SLSD_WORD_RST = 8'h00;
    localparam logic SLSD_BIT_RST = 1'b0;
    // previous shift and latch clock pin levels idle low
    localparam logic SLSD_CLK_IDLE = 1'b0;

    typedef logic [SLSD_STAGES-1:0] slsd_word_t;

    // host-side pins, grouped as they arrive
    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic latch_clock;
        logic clear_n;
        logic output_enable_n;
    } slsd_pins_s;

endpackage

// *** core/slsd_fifo.sv ***
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset, flush input
// Notes: full and empty derive from an occupancy counter
`timescale 1ns/1ps
module slsd_fifo
    import slsd_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic flush_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] COUNT_FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == PTR_LAST) ? '0 : AW'(p + 1'b1);
    endfunction

    assign wr_ready_out = (count_q != COUNT_FULL);
    assign rd_valid_out = (count_q != '0);
    assign rd_data_out = mem_q[rd_ptr_q];
    assign push = wr_valid_in && wr_ready_out && enable_in;
    assign pop = rd_valid_out && rd_ready_in && enable_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || (enable_in && flush_in)) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

// *** core/slsd_driver.sv ***
// Purpose: 8-stage serial shift chain, storage register, sink drivers
// Assumes: pins are synchronous to clk_in; clock pins are edge-detected
// Notes: latched words queue in a FIFO before reaching storage
`timescale 1ns/1ps

// Function
// RQ1: each shift_clock rise takes serial_in into stage 0, moves stages up.
// RQ2: chain is eight stages; serial_out shows the last stage for cascading.
// RQ3: latch_clock rise copies all stages; storage holds between rises. Code queues each rise if not full; storage pops it while storage_hold_in is low.
// RQ4: clear_n low zeroes shift chain, storage and output buffer.
// RQ5: storage passes to output buffer only while clear_n is high.
// RQ6: output enable low drives each sink from its storage bit.
// RQ7: output enable high holds all eight sinks off.
// RQ8: a sink conducts only for a one bit; zero leaves it off.
// RQ9: serial_out updates on shift_clock falling edge.
// RQ10: stage n drives channel n; first bit in lands on channel 7.
module slsd_driver
    import slsd_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = SLSD_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire slsd_pins_s pins_in,
    input wire logic storage_hold_in,
    output logic latch_ready_out,
    output logic serial_out,
    output slsd_word_t sink_level_out,
    output slsd_word_t sink_oe_out
);

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic shift_prev_q;
    logic latch_prev_q;
    logic shift_rise;
    logic shift_fall;
    logic latch_rise;
    logic clearing;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shift_prev_q <= SLSD_CLK_IDLE;
            latch_prev_q <= SLSD_CLK_IDLE;
        end else if (enable_in) begin
            shift_prev_q <= pins_in.shift_clock;
            latch_prev_q <= pins_in.latch_clock;
        end
    end

    assign shift_rise = pins_in.shift_clock && !shift_prev_q;
    assign shift_fall = !pins_in.shift_clock && shift_prev_q;
    assign latch_rise = pins_in.latch_clock && !latch_prev_q;
    assign clearing = !pins_in.clear_n;

    // ----------------------------------------------------------------
    // shift chain and serial output
    // ----------------------------------------------------------------
    slsd_word_t shift_q;
    logic serial_q;

    always_ff @(posedge clk_in) begin
        if (reset_in || (enable_in && clearing)) begin
            shift_q <= SLSD_WORD_RST; // RQ4
        end else if (enable_in && shift_rise) begin
            // stage 0 is fed, so the first bit walks to stage 7
            shift_q <= {shift_q[SLSD_STAGES-2:0], pins_in.serial_in}; // RQ1 RQ10
        end
    end

    // half-period delay gives a chained part extra hold margin
    always_ff @(posedge clk_in) begin
        if (reset_in || (enable_in && clearing)) begin
            serial_q <= SLSD_BIT_RST;
        end else if (enable_in && shift_fall) begin
            serial_q <= shift_q[SLSD_STAGES-1]; // RQ2 RQ9
        end
    end

    assign serial_out = serial_q;

    // ----------------------------------------------------------------
    // latch queue
    // ----------------------------------------------------------------
    // a latch edge while the queue is full is dropped; latch_ready_out
    // warns the host so it can slow its latch rate
    slsd_word_t queue_word;
    logic queue_valid;
    logic queue_take;

    assign queue_take = !storage_hold_in && pins_in.clear_n;

    slsd_fifo #(
        .WIDTH(SLSD_STAGES),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .flush_in(clearing),
        .wr_data_in(shift_q),
        .wr_valid_in(latch_rise && pins_in.clear_n), // RQ3
        .wr_ready_out(latch_ready_out),
        .rd_data_out(queue_word),
        .rd_valid_out(queue_valid),
        .rd_ready_in(queue_take)
    );

    // ----------------------------------------------------------------
    // storage register and output buffer
    // ----------------------------------------------------------------
    slsd_word_t storage_q;
    slsd_word_t buffer_q;
    slsd_word_t oe_q;

    always_ff @(posedge clk_in) begin
        if (reset_in || (enable_in && clearing)) begin
            storage_q <= SLSD_WORD_RST; // RQ4
        end else if (enable_in && queue_valid && queue_take) begin
            storage_q <= queue_word; // RQ3
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || (enable_in && clearing)) begin
            buffer_q <= SLSD_WORD_RST; // RQ4
        end else if (enable_in) begin
            buffer_q <= storage_q; // RQ5
        end
    end

    // enable gated after the buffer so its change shows in one cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            oe_q <= SLSD_WORD_RST;
        end else if (enable_in) begin
            if (pins_in.output_enable_n) begin
                oe_q <= SLSD_WORD_RST; // RQ7
            end else begin
                oe_q <= buffer_q; // RQ6 RQ8 RQ10
            end
        end
    end

    assign sink_oe_out = oe_q;
    // an open-drain sink only ever pulls low
    assign sink_level_out = SLSD_WORD_RST;

endmodule

// *** test/slsd_host.sv ***
// Purpose: host model driving serial data, clocks, clear and enable
// Assumes: pins change at falling clk_in, each level held at least one cycle
// Notes: serial_in turns inverse after each bit, no stale level
`timescale 1ns/1ps
module slsd_host
    import slsd_pkg::*;
(
    input wire logic clk_in,
    output slsd_pins_s pins_out
);
    initial pins_out = 5'b00010;
    task automatic pulse(input int sel);
        @(negedge clk_in);
        pins_out.shift_clock = (sel == 0);
        pins_out.latch_clock = (sel != 0);
        @(negedge clk_in);
        pins_out.shift_clock = 1'b0;
        pins_out.latch_clock = 1'b0;
        pins_out.serial_in = ~pins_out.serial_in;
        // let the falling-edge update land before the caller looks
        @(negedge clk_in);
    endtask
    task automatic shift_bit(input logic b);
        @(negedge clk_in);
        pins_out.serial_in = b;
        pulse(0);
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        @(negedge clk_in);
        pins_out.clear_n = clr_n;
        pins_out.output_enable_n = oe_n;
    endtask
endmodule

// *** test/slsd_driver_sva.sv ***
// Purpose: port-level checks of the shift/latch sink driver
// Assumes: enable_in high whenever pins change
// Notes: latency figures follow the hand-over contract
`timescale 1ns/1ps
module slsd_driver_sva
    import slsd_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire slsd_pins_s pins_in,
    input wire logic storage_hold_in,
    input wire logic latch_ready_out,
    input wire logic serial_out,
    input wire slsd_word_t sink_level_out,
    input wire slsd_word_t sink_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire logic live = enable_in && pins_in.clear_n;
    oe_off_a: assert property (
        enable_in && pins_in.output_enable_n |=> sink_oe_out == 8'h00
    ) else $error("sink on while disabled");
    oe_cause_a: assert property (
        sink_oe_out != 8'h00 |-> $past(!pins_in.output_enable_n)
    ) else $error("sink on without enable");
    level_zero_a: assert property (
        sink_level_out == 8'h00) else $error("sink level not low");
    clr_serial_a: assert property (
        enable_in && !pins_in.clear_n |=> !serial_out
    ) else $error("serial out not cleared");
    clr_sink_a: assert property (
        (enable_in && !pins_in.clear_n) [*3] |=> sink_oe_out == 8'h00
    ) else $error("sinks not cleared");
    clr_flush_a: assert property (
        enable_in && !pins_in.clear_n |=> latch_ready_out
    ) else $error("queue not flushed");
    serial_hold_a: assert property (
        live && !(!pins_in.shift_clock && $past(pins_in.shift_clock))
        |=> $stable(serial_out)) else $error("serial out moved early");
    hold_stable_a: assert property (
        (live && storage_hold_in && !pins_in.output_enable_n) [*4]
        |-> $stable(sink_oe_out)) else $error("storage moved while held");
endmodule
bind slsd_driver slsd_driver_sva slsd_driver_sva_inst (.*);

// *** test/tb_top.sv ***
// Purpose: self-checking bench of the shift/latch sink driver
// Assumes: queue depth 4 so that it fills quickly
// Notes: enable_in stays high throughout
`timescale 1ns/1ps
module tb_top
    import slsd_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic enable_in = 1'b1;
    logic storage_hold_in = 1'b0;
    logic latch_ready_out;
    logic serial_out;
    slsd_pins_s pins;
    slsd_word_t sink_level_out;
    slsd_word_t sink_oe_out;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    slsd_host host_inst (.clk_in(clk_in), .pins_out(pins));
    slsd_driver #(.FIFO_DEPTH(4)) slsd_driver_inst (.clk_in(clk_in),
        .reset_in(reset_in), .enable_in(enable_in), .pins_in(pins),
        .storage_hold_in(storage_hold_in),
        .latch_ready_out(latch_ready_out), .serial_out(serial_out),
        .sink_level_out(sink_level_out), .sink_oe_out(sink_oe_out));
    initial forever #2 clk_in = ~clk_in;
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard: the full run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    task automatic load(input logic [7:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) host_inst.shift_bit(w[i]);
    endtask
    task automatic latch_settle();
        host_inst.pulse(1);
        repeat (6) @(negedge clk_in);
    endtask
    task automatic t_data();
        load(8'hA5, 8);
        check("serial_out", {7'h00, serial_out}, 8'h01);
        latch_settle();
        check("sinks", sink_oe_out, 8'hA5);
        check("level", sink_level_out, 8'h00);
        host_inst.shift_bit(1'b1);
        check("serial_out", {7'h00, serial_out}, 8'h00);
        load(8'hC3, 7);
        check("serial_out", {7'h00, serial_out}, 8'h01);
        check("sinks", sink_oe_out, 8'hA5);
        $display("t_data done");
    endtask
    task automatic t_enable();
        host_inst.set_pins(1'b1, 1'b1);
        repeat (2) @(negedge clk_in);
        check("sinks", sink_oe_out, 8'h00);
        host_inst.set_pins(1'b1, 1'b0);
        repeat (2) @(negedge clk_in);
        check("sinks", sink_oe_out, 8'hA5);
        $display("t_enable done");
    endtask
    task automatic t_queue();
        storage_hold_in = 1'b1;
        repeat (4) host_inst.pulse(1);
        check("ready", {7'h00, latch_ready_out}, 8'h00);
        latch_settle();
        check("sinks", sink_oe_out, 8'hA5);
        storage_hold_in = 1'b0;
        repeat (12) @(negedge clk_in);
        check("ready", {7'h00, latch_ready_out}, 8'h01);
        check("sinks", sink_oe_out, 8'hC3);
        $display("t_queue done");
    endtask
    task automatic t_clear();
        host_inst.set_pins(1'b0, 1'b0);
        repeat (4) @(negedge clk_in);
        check("sinks", sink_oe_out, 8'h00);
        check("serial_out", {7'h00, serial_out}, 8'h00);
        host_inst.set_pins(1'b1, 1'b0);
        latch_settle();
        check("sinks", sink_oe_out, 8'h00);
        $display("t_clear done");
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        t_data();
        t_enable();
        t_queue();
        t_clear();
        tally_and_finish();
    end
endmodule
